// ==== design/fpr_flash_cmd_protect.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// - errors during command or reset set status
// - completion irq requested when enabled and done
// - mass erase request set at start, cleared after
// - software cannot write mass erase request
// - mass erase: erase, verify, program security, unsecure
// - reserved bits read zero, except the protection byte's reserved bit, which reads its loaded value
// - six 16-bit command words selected by index
// - command object reachable with byte accesses
// - low register bits 7:0, high bits 15:8
// - protection writes may only grow protection
// - protection loaded from nonvolatile byte at reset
// - protected program or erase sets violation flag
// - block erase refused if any sector protected
// - operation select chooses protect or unprotect meaning
// - upper range disable controls range ending 0x7FFF
// - upper size writable only while upper disabled
// - lower range disable controls range from zero
// - lower size writable only while lower disabled
// - option byte loaded from nonvolatile at reset
// - writing one to done flag launches command
// - violation flag write-one-clear, blocks launches
module fpr_flash_cmd_protect (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire fpr_pkg::fpr_wb_req_t wb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic mass_erase_i,
   output logic nv_rd_o,
   output logic [15:0] nv_addr_o,
   input wire logic [7:0] nv_data_i,
   input wire logic nv_valid_i,
   input wire logic nv_dbl_fault_i,
   output logic mc_start_o,
   output fpr_pkg::fpr_mcop_t mc_op_o,
   output logic [fpr_pkg::COB_WORDS*16-1:0] mc_cob_o,
   input wire logic mc_done_i,
   input wire logic [1:0] mc_err_i,
   output logic done_irq_o,
   output logic unsecure_o,
   output logic [7:0] protect_o,
   output logic [7:0] option_o
);

   fpr_pkg::fpr_state_t q;
   fpr_pkg::fpr_state_t d;

   logic acc;
   logic wr;
   logic [7:0] widx;
   logic [7:0] wbyte;
   logic me_rise;
   logic cob_ok;
   logic launch_try;
   logic [7:0] cmd_code;
   logic cmd_refused;

   // true when addr lies in a protected area
   function automatic logic prot_hit(input logic [7:0] p, input logic [15:0] addr);
      logic [16:0] hsz;
      logic [16:0] lsz;
      logic [16:0] a;
      logic hin;
      logic lin;
      hsz = fpr_pkg::UPPER_UNIT << p[fpr_pkg::PR_HS_LSB +: 2];
      lsz = fpr_pkg::LOWER_UNIT << p[fpr_pkg::PR_LS_LSB +: 2];
      a = {1'b0, addr};
      hin = ~p[fpr_pkg::PR_HDIS_BIT] && (a <= fpr_pkg::UPPER_END) &&
            (a >= 17'(fpr_pkg::UPPER_END + 17'h00001 - hsz));
      lin = ~p[fpr_pkg::PR_LDIS_BIT] && (a >= fpr_pkg::LOWER_BASE) &&
            (a < 17'(fpr_pkg::LOWER_BASE + lsz));
      // select sets the meaning of the ranges
      if (p[fpr_pkg::PR_POPEN_BIT]) begin
         prot_hit = hin | lin;
      end else begin
         prot_hit = ~(hin | lin);
      end
   endfunction

   // any sector protected at all, used to refuse a whole-block erase
   function automatic logic any_prot(input logic [7:0] p);
      if (p[fpr_pkg::PR_POPEN_BIT]) begin
         any_prot = ~p[fpr_pkg::PR_HDIS_BIT] | ~p[fpr_pkg::PR_LDIS_BIT];
      end else begin
         any_prot = 1'b1; // ranges never cover the whole array here
      end
   endfunction

   // merge a software write so protection can only grow
   function automatic logic [7:0] prot_merge(input logic [7:0] o, input logic [7:0] w);
      logic [7:0] n;
      logic p;
      n = o; // reserved nonvolatile bit keeps its loaded value
      p = o[fpr_pkg::PR_POPEN_BIT] & w[fpr_pkg::PR_POPEN_BIT];
      n[fpr_pkg::PR_POPEN_BIT] = p;
      if (p) begin
         n[fpr_pkg::PR_HDIS_BIT] = o[fpr_pkg::PR_HDIS_BIT] & w[fpr_pkg::PR_HDIS_BIT];
         n[fpr_pkg::PR_LDIS_BIT] = o[fpr_pkg::PR_LDIS_BIT] & w[fpr_pkg::PR_LDIS_BIT];
      end else begin
         n[fpr_pkg::PR_HDIS_BIT] = o[fpr_pkg::PR_HDIS_BIT] | w[fpr_pkg::PR_HDIS_BIT];
         n[fpr_pkg::PR_LDIS_BIT] = o[fpr_pkg::PR_LDIS_BIT] | w[fpr_pkg::PR_LDIS_BIT];
      end
      if (o[fpr_pkg::PR_HDIS_BIT]) begin
         n[fpr_pkg::PR_HS_LSB +: 2] = w[fpr_pkg::PR_HS_LSB +: 2];
      end
      if (o[fpr_pkg::PR_LDIS_BIT]) begin
         n[fpr_pkg::PR_LS_LSB +: 2] = w[fpr_pkg::PR_LS_LSB +: 2];
      end
      prot_merge = n;
   endfunction

   // bus decode helpers; one wait state, ack never repeats back to back
   assign acc = wb_i.cyc & wb_i.stb & ~q.ack;
   assign wr = acc & wb_i.we & wb_i.sel[0];
   assign widx = 8'(wb_i.adr[fpr_pkg::ADR_W-1:2]);
   assign wbyte = wb_i.dat[7:0];
   assign me_rise = q.me_s2 & ~q.me_prev;
   // command words only change between commands and without pending errors
   assign cob_ok = q.cmd_done_flag & ~q.access_error_flag & ~q.protect_violation_flag & (q.fsm == fpr_pkg::FS_IDLE) &
                   (q.idx < 3'(fpr_pkg::COB_WORDS));
   assign launch_try = wr && (widx == fpr_pkg::IDX_STATUS) && wbyte[fpr_pkg::ST_CMD_DONE_FLAG_BIT] &&
                       q.cmd_done_flag && ~q.access_error_flag && ~q.protect_violation_flag && (q.fsm == fpr_pkg::FS_IDLE);
   assign cmd_code = q.cob[0][15:8];
   assign cmd_refused = ((cmd_code == fpr_pkg::CMD_PROGRAM ||
                          cmd_code == fpr_pkg::CMD_ERASE_SECTOR) &&
                         prot_hit(q.prot, q.cob[1])) ||
                        (cmd_code == fpr_pkg::CMD_ERASE_BLOCK && any_prot(q.prot));

   // next state: sequencer first, then software writes, then read data
   always_comb begin
      logic [7:0] rb;
      rb = 8'h00;
      d = q;
      d.ack = 1'b0;
      d.mc_start = 1'b0;
      d.nv_rd = 1'b0;
      d.me_s1 = mass_erase_i;
      d.me_s2 = q.me_s1;
      d.me_prev = q.me_s2;
      case (q.fsm)
         fpr_pkg::FS_LOAD_PROT: begin
            d.nv_rd = 1'b1;
            d.nv_addr = fpr_pkg::NV_PROT_ADDR;
            d.fsm = fpr_pkg::FS_WAIT_PROT;
         end
         fpr_pkg::FS_WAIT_PROT: begin
            if (nv_valid_i) begin
               d.prot = nv_data_i;
               if (nv_dbl_fault_i) begin
                  d.cmd_error_status = q.cmd_error_status | fpr_pkg::MG_NV_FAULT;
               end
               d.fsm = fpr_pkg::FS_LOAD_OPT;
            end
         end
         fpr_pkg::FS_LOAD_OPT: begin
            d.nv_rd = 1'b1;
            d.nv_addr = fpr_pkg::NV_OPT_ADDR;
            d.fsm = fpr_pkg::FS_WAIT_OPT;
         end
         fpr_pkg::FS_WAIT_OPT: begin
            if (nv_valid_i) begin
               d.opt = nv_data_i;
               if (nv_dbl_fault_i) begin
                  d.cmd_error_status = q.cmd_error_status | fpr_pkg::MG_NV_FAULT;
               end
               d.cmd_done_flag = 1'b1;
               d.fsm = fpr_pkg::FS_IDLE;
            end
         end
         fpr_pkg::FS_IDLE: begin
            // debugger request wins over a software launch in the same cycle
            if (me_rise) begin
               d.me_req = 1'b1;
               d.cmd_done_flag = 1'b0;
               d.mc_op = fpr_pkg::MC_ERASE_ALL;
               d.mc_start = 1'b1;
               d.fsm = fpr_pkg::FS_MASS;
            end
         end
         fpr_pkg::FS_CMD: begin
            if (mc_done_i) begin
               d.cmd_error_status = mc_err_i;
               d.cmd_done_flag = 1'b1;
               d.fsm = fpr_pkg::FS_IDLE;
            end
         end
         fpr_pkg::FS_MASS: begin
            if (mc_done_i) begin
               if (mc_err_i != 2'h0) begin
                  // abort: security stays as it was
                  d.cmd_error_status = mc_err_i;
                  d.me_req = 1'b0;
                  d.cmd_done_flag = 1'b1;
                  d.fsm = fpr_pkg::FS_IDLE;
               end else if (q.mc_op == fpr_pkg::MC_ERASE_ALL) begin
                  d.mc_op = fpr_pkg::MC_VERIFY;
                  d.mc_start = 1'b1;
               end else if (q.mc_op == fpr_pkg::MC_VERIFY) begin
                  d.mc_op = fpr_pkg::MC_PROG_SEC;
                  d.mc_start = 1'b1;
               end else begin
                  d.unsec = 1'b1;
                  d.me_req = 1'b0;
                  d.cmd_done_flag = 1'b1;
                  d.fsm = fpr_pkg::FS_IDLE;
               end
            end
         end
         default: begin
            d.fsm = fpr_pkg::FS_IDLE;
         end
      endcase
      // software writes, low byte lane only
      if (wr) begin
         if (widx == fpr_pkg::IDX_CMD_INDEX) begin
            if (q.cmd_done_flag) begin
               d.idx = wbyte[fpr_pkg::IDX_W-1:0];
            end
         end else if (widx == fpr_pkg::IDX_CONFIG) begin
            // only the enable is stored; request and reserved bits stay untouched
            d.ie = wbyte[fpr_pkg::CFG_IE_BIT];
         end else if (widx == fpr_pkg::IDX_STATUS) begin
            if (wbyte[fpr_pkg::ST_ACCESS_ERROR_FLAG_BIT]) begin
               d.access_error_flag = 1'b0;
            end
            if (wbyte[fpr_pkg::ST_PROTECT_VIOLATION_FLAG_BIT]) begin
               d.protect_violation_flag = 1'b0;
            end
            if (launch_try && d.fsm == fpr_pkg::FS_IDLE) begin
               if (cmd_refused) begin
                  d.protect_violation_flag = 1'b1;
               end else begin
                  d.cmd_done_flag = 1'b0;
                  d.cmd_error_status = 2'h0;
                  d.mc_op = fpr_pkg::MC_CMD;
                  d.mc_start = 1'b1;
                  d.fsm = fpr_pkg::FS_CMD;
               end
            end
         end else if (widx == fpr_pkg::IDX_COB_LO) begin
            if (cob_ok) begin
               d.cob[q.idx][7:0] = wbyte;
            end else if (~q.cmd_done_flag) begin
               d.access_error_flag = 1'b1;
            end
         end else if (widx == fpr_pkg::IDX_COB_HI) begin
            if (cob_ok) begin
               d.cob[q.idx][15:8] = wbyte;
            end else if (~q.cmd_done_flag) begin
               d.access_error_flag = 1'b1;
            end
         end else if (widx == fpr_pkg::IDX_PROT) begin
            d.prot = prot_merge(q.prot, wbyte);
         end
      end
      // read mux; unmapped words and reserved bits read zero, except protection bit 6, which reads as loaded
      if (widx == fpr_pkg::IDX_CMD_INDEX) begin
         rb = {5'h00, q.idx};
      end else if (widx == fpr_pkg::IDX_CONFIG) begin
         rb[fpr_pkg::CFG_IE_BIT] = q.ie;
         rb[fpr_pkg::CFG_ME_BIT] = q.me_req;
      end else if (widx == fpr_pkg::IDX_STATUS) begin
         rb[fpr_pkg::ST_CMD_DONE_FLAG_BIT] = q.cmd_done_flag;
         rb[fpr_pkg::ST_ACCESS_ERROR_FLAG_BIT] = q.access_error_flag;
         rb[fpr_pkg::ST_PROTECT_VIOLATION_FLAG_BIT] = q.protect_violation_flag;
         rb[fpr_pkg::ST_BUSY_BIT] = (q.fsm == fpr_pkg::FS_CMD) | (q.fsm == fpr_pkg::FS_MASS);
         rb[1:0] = q.cmd_error_status;
      end else if (widx == fpr_pkg::IDX_COB_LO) begin
         if (q.idx < 3'(fpr_pkg::COB_WORDS)) begin
            rb = q.cob[q.idx][7:0];
         end
      end else if (widx == fpr_pkg::IDX_COB_HI) begin
         if (q.idx < 3'(fpr_pkg::COB_WORDS)) begin
            rb = q.cob[q.idx][15:8];
         end
      end else if (widx == fpr_pkg::IDX_PROT) begin
         rb = q.prot;
      end else if (widx == fpr_pkg::IDX_OPT) begin
         rb = q.opt;
      end
      if (acc) begin
         d.ack = 1'b1;
         d.rdat = {24'h000000, rb};
      end
      d.irq = d.ie & d.cmd_done_flag;
   end

   // option and command words are undefined before load; zero chosen
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state register
   assign wb_dat_o = q.rdat;
   assign wb_ack_o = q.ack;
   assign nv_rd_o = q.nv_rd;
   assign nv_addr_o = q.nv_addr;
   assign mc_start_o = q.mc_start;
   assign mc_op_o = q.mc_op;
   assign mc_cob_o = q.cob;
   assign done_irq_o = q.irq;
   assign unsecure_o = q.unsec;
   assign protect_o = q.prot;
   assign option_o = q.opt;

   chk_irq_gate: assert property (@(posedge mclk_i) disable iff (reset_i)
      (q.cmd_done_flag && $past(q.cmd_done_flag) && !q.ie) |-> !done_irq_o)
      else $error("irq raised while disabled");
   chk_mass_start: assert property (@(posedge mclk_i) disable iff (reset_i)
      (q.fsm == fpr_pkg::FS_IDLE && me_rise) |=> (q.me_req && mc_start_o))
      else $error("mass erase request not set at start");
   chk_mass_order: assert property (@(posedge mclk_i) disable iff (reset_i)
      (q.fsm == fpr_pkg::FS_MASS && mc_done_i && mc_err_i == 2'h0 &&
       q.mc_op == fpr_pkg::MC_ERASE_ALL) |=> (mc_start_o && q.mc_op == fpr_pkg::MC_VERIFY))
      else $error("verify does not follow erase");
   chk_me_readonly: assert property (@(posedge mclk_i) disable iff (reset_i)
      (wr && widx == fpr_pkg::IDX_CONFIG && q.fsm == fpr_pkg::FS_IDLE && !me_rise)
      |=> (q.me_req == $past(q.me_req)))
      else $error("mass erase request written by software");
   chk_reserved_zero: assert property (@(posedge mclk_i) disable iff (reset_i)
      wb_ack_o |-> (wb_dat_o[31:8] == 24'h000000))
      else $error("reserved read bits not zero");
   chk_cob_write: assert property (@(posedge mclk_i) disable iff (reset_i)
      (wr && widx == fpr_pkg::IDX_COB_LO && cob_ok)
      |=> (q.cob[$past(q.idx)][7:0] == $past(wbyte)))
      else $error("command object low byte not stored");
   chk_prot_refuse: assert property (@(posedge mclk_i) disable iff (reset_i)
      (launch_try && cmd_refused) |=> (q.protect_violation_flag && !mc_start_o && q.cmd_done_flag))
      else $error("protected command not refused");
   chk_popen_grow: assert property (@(posedge mclk_i) disable iff (reset_i)
      (wr && widx == fpr_pkg::IDX_PROT && !q.prot[fpr_pkg::PR_POPEN_BIT])
      |=> !q.prot[fpr_pkg::PR_POPEN_BIT])
      else $error("protection select shrank protection");
   chk_size_lock: assert property (@(posedge mclk_i) disable iff (reset_i)
      (wr && widx == fpr_pkg::IDX_PROT && !q.prot[fpr_pkg::PR_HDIS_BIT])
      |=> (q.prot[fpr_pkg::PR_HS_LSB +: 2] == $past(q.prot[fpr_pkg::PR_HS_LSB +: 2])))
      else $error("upper size changed while range enabled");
   chk_opt_load: assert property (@(posedge mclk_i) disable iff (reset_i)
      (q.fsm == fpr_pkg::FS_WAIT_OPT && nv_valid_i) |=> (option_o == $past(nv_data_i)))
      else $error("option byte not loaded");
   chk_cmd_error: assert property (@(posedge mclk_i) disable iff (reset_i)
      (q.fsm == fpr_pkg::FS_CMD && mc_done_i && mc_err_i != 2'h0)
      |=> (q.cmd_error_status == $past(mc_err_i) && q.cmd_done_flag))
      else $error("command error not recorded");
   chk_viol_block: assert property (@(posedge mclk_i) disable iff (reset_i)
      (q.protect_violation_flag && wr && widx == fpr_pkg::IDX_STATUS) |=> !mc_start_o)
      else $error("launch accepted during violation");
   // lower size is frozen while the lower range is active
   chk_low_size_lock: assert property (@(posedge mclk_i) disable iff (reset_i)
      (wr && widx == fpr_pkg::IDX_PROT && !q.prot[fpr_pkg::PR_LDIS_BIT])
      |=> (q.prot[fpr_pkg::PR_LS_LSB +: 2] == $past(q.prot[fpr_pkg::PR_LS_LSB +: 2])))
      else $error("lower size changed while range enabled");
   chk_prot_load: assert property (@(posedge mclk_i) disable iff (reset_i)
      (q.fsm == fpr_pkg::FS_WAIT_PROT && nv_valid_i) |=> (protect_o == $past(nv_data_i)))
      else $error("protection byte not loaded");
   // done flag must stay low for the whole user command
   chk_busy_flag_low: assert property (@(posedge mclk_i) disable iff (reset_i)
      (q.fsm == fpr_pkg::FS_CMD) |-> !q.cmd_done_flag)
      else $error("done flag high during command");
   chk_block_refuse: assert property (@(posedge mclk_i) disable iff (reset_i)
      (launch_try && cmd_code == fpr_pkg::CMD_ERASE_BLOCK && any_prot(q.prot))
      |=> (!mc_start_o && q.protect_violation_flag))
      else $error("block erase started with protection active");

endmodule

// ==== design/fpr_pkg.sv ====
package fpr_pkg;
   // register word indices; byte address is four times the index
   localparam logic [7:0] IDX_CMD_INDEX = 8'h02;
   localparam logic [7:0] IDX_CONFIG = 8'h04;
   localparam logic [7:0] IDX_STATUS = 8'h05;
   localparam logic [7:0] IDX_COB_LO = 8'h08;
   localparam logic [7:0] IDX_COB_HI = 8'h09;
   localparam logic [7:0] IDX_PROT = 8'h0B;
   localparam logic [7:0] IDX_OPT = 8'h0F;
   localparam int ADR_W = 10;

   // flash_config fields
   localparam int CFG_IE_BIT = 7;
   localparam int CFG_ME_BIT = 5;
   // status_register fields
   localparam int ST_CMD_DONE_FLAG_BIT = 7;
   localparam int ST_ACCESS_ERROR_FLAG_BIT = 5;
   localparam int ST_PROTECT_VIOLATION_FLAG_BIT = 4;
   localparam int ST_BUSY_BIT = 3;
   // protection_control fields
   localparam int PR_POPEN_BIT = 7;
   localparam int PR_HDIS_BIT = 5;
   localparam int PR_HS_LSB = 3;
   localparam int PR_LDIS_BIT = 2;
   localparam int PR_LS_LSB = 0;

   // command object storage
   localparam int COB_WORDS = 6;
   localparam int IDX_W = 3;

   // nonvolatile configuration bytes fetched by the reset sequence
   localparam logic [15:0] NV_PROT_ADDR = 16'h040D;
   localparam logic [15:0] NV_OPT_ADDR = 16'h040F;

   // protection range geometry
   localparam logic [16:0] UPPER_END = 17'h07FFF;
   localparam logic [16:0] LOWER_BASE = 17'h00000;
   localparam logic [16:0] UPPER_UNIT = 17'h00400;
   localparam logic [16:0] LOWER_UNIT = 17'h00800;

   // command codes seen in word 0 bits 15:8
   localparam logic [7:0] CMD_PROGRAM = 8'h01;
   localparam logic [7:0] CMD_ERASE_SECTOR = 8'h02;
   localparam logic [7:0] CMD_ERASE_BLOCK = 8'h03;

   // completion status code for a faulted nonvolatile load
   localparam logic [1:0] MG_NV_FAULT = 2'h2;

   typedef enum logic [2:0] {
      FS_LOAD_PROT = 3'b000,
      FS_WAIT_PROT = 3'b001,
      FS_LOAD_OPT = 3'b010,
      FS_WAIT_OPT = 3'b011,
      FS_IDLE = 3'b100,
      FS_CMD = 3'b101,
      FS_MASS = 3'b110
   } fpr_fsm_t;

   typedef enum logic [1:0] {
      MC_CMD = 2'b00,
      MC_ERASE_ALL = 2'b01,
      MC_VERIFY = 2'b10,
      MC_PROG_SEC = 2'b11
   } fpr_mcop_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [ADR_W-1:0] adr;
      logic [31:0] dat;
   } fpr_wb_req_t;

   typedef struct packed {
      fpr_fsm_t fsm;
      logic ack;
      logic [31:0] rdat;
      logic cmd_done_flag;
      logic access_error_flag;
      logic protect_violation_flag;
      logic [1:0] cmd_error_status;
      logic ie;
      logic me_req;
      logic [IDX_W-1:0] idx;
      logic [COB_WORDS-1:0][15:0] cob;
      logic [7:0] prot;
      logic [7:0] opt;
      logic mc_start;
      fpr_mcop_t mc_op;
      logic nv_rd;
      logic [15:0] nv_addr;
      logic irq;
      logic unsec;
      logic me_s1;
      logic me_s2;
      logic me_prev;
   } fpr_state_t;
endpackage

// ==== dv/flash_cmd_protect_regs_tb.sv ====
`timescale 1ns/10ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module flash_cmd_protect_regs_tb;
   logic mclk_i = 1'h0;
   logic reset_i = 1'h1;
   fpr_pkg::fpr_wb_req_t wb = '0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, mass_erase_i = 1'h0, nv_rd_o, nv_valid_i = 1'h0, nv_dbl_fault_i = 1'h0;
   logic [15:0] nv_addr_o;
   logic [7:0] nv_data_i = 8'h00, protect_o, option_o, opt;
   logic mc_start_o, mc_done_i = 1'h0, done_irq_o, unsecure_o;
   logic [1:0] mc_err_i = 2'h0;
   fpr_pkg::fpr_mcop_t mc_op_o;
   logic [fpr_pkg::COB_WORDS*16-1:0] mc_cob_o;
   logic [31:0] seed = 32'h0E705062;
   logic [31:0] rd;
   logic [15:0] words [7];
   logic [7:0] pw [4] = '{8'hDC, 8'hA4, 8'h9B, 8'h98};
   logic [7:0] pe [4] = '{8'h9C, 8'h9C, 8'h9B, 8'h9B};
   int n_mismatch = 0, compares = 0, n_start = 0, cycles = 0, s;

   // 40 MHz design clock
   always #12.5 mclk_i = ~mclk_i;

   fpr_flash_cmd_protect DUT (
      .mclk_i(mclk_i), .reset_i(reset_i), .wb_i(wb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .mass_erase_i(mass_erase_i), .nv_rd_o(nv_rd_o), .nv_addr_o(nv_addr_o),
      .nv_data_i(nv_data_i), .nv_valid_i(nv_valid_i), .nv_dbl_fault_i(nv_dbl_fault_i),
      .mc_start_o(mc_start_o), .mc_op_o(mc_op_o), .mc_cob_o(mc_cob_o), .mc_done_i(mc_done_i),
      .mc_err_i(mc_err_i), .done_irq_o(done_irq_o), .unsecure_o(unsecure_o),
      .protect_o(protect_o), .option_o(option_o)
   );

   // start pulses are counted here so a refused launch can be seen as no pulse at all
   always @(posedge mclk_i) begin
      if (mc_start_o === 1'h1) n_start <= n_start + 1;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic ticks(input int k);
      repeat (k) @(posedge mclk_i);
   endtask

   // classic single cycle; entered just after an edge, leaves one idle cycle behind it
   task automatic wb_xfer(input logic we, input logic [9:0] adr, input logic [7:0] dat);
      int n;
      n = 0;
      wb <= '{cyc: 1'h1, stb: 1'h1, we: we, sel: 4'h1, adr: adr, dat: {24'h000000, dat}};
      do begin
         @(posedge mclk_i);
         n++;
      end while (wb_ack_o !== 1'h1 && n < 50);
      if (n == 50) n_mismatch++;
      rd = wb_dat_o;
      wb <= '0;
      @(posedge mclk_i);
   endtask

   task automatic rd_chk(input logic [9:0] adr, input logic [7:0] exp);
      wb_xfer(1'h0, adr, 8'h00);
      `CHK(rd, {24'h000000, exp})
   endtask

   // answer both nonvolatile fetches; a fault is only ever put on the option byte
   task automatic nv_load(input logic [7:0] pv, input logic [7:0] ov, input logic flt);
      for (int k = 0; k < 2; k++) begin
         int n;
         n = 0;
         while (nv_rd_o !== 1'h1 && n < 50) begin
            @(posedge mclk_i);
            n++;
         end
         `CHK(nv_addr_o, k ? fpr_pkg::NV_OPT_ADDR : fpr_pkg::NV_PROT_ADDR)
         nv_valid_i <= 1'h1;
         nv_data_i <= k ? ov : pv;
         nv_dbl_fault_i <= (k == 1) && flt;
         @(posedge mclk_i);
         nv_valid_i <= 1'h0;
         nv_dbl_fault_i <= 1'h0;
         nv_data_i <= ~nv_data_i;
         @(posedge mclk_i);
      end
      ticks(2);
      `CHK(protect_o, pv)
      if (!flt) `CHK(option_o, ov)
   endtask

   task automatic do_reset(input logic [7:0] pv, input logic flt);
      reset_i <= 1'h1;
      ticks(16);
      reset_i <= 1'h0;
      seed = lfsr_next(seed);
      opt = seed[7:0];
      nv_load(pv, opt, flt);
   endtask

   task automatic set_word(input int i, input logic [15:0] v);
      wb_xfer(1'h1, 10'h008, i[7:0]);
      wb_xfer(1'h1, 10'h020, v[7:0]);
      wb_xfer(1'h1, 10'h024, v[15:8]);
   endtask

   // one command through the status register; completion interrupt is enabled by the caller
   task automatic launch(input logic [7:0] code, input logic [15:0] adr, input logic go,
         input logic [1:0] err);
      set_word(0, {code, 8'h00});
      set_word(1, adr);
      s = n_start;
      wb_xfer(1'h1, 10'h014, 8'h80);
      ticks(3);
      `CHK(n_start, s + go)
      if (go) begin
         `CHK(mc_op_o, fpr_pkg::MC_CMD)
         `CHK(mc_cob_o[31:16], adr)
         rd_chk(10'h014, 8'h08);
         wb_xfer(1'h1, 10'h020, 8'h5A);
         rd_chk(10'h014, 8'h28);
         `CHK(done_irq_o, 1'h0)
         mc_err_i <= err;
         mc_done_i <= 1'h1;
         @(posedge mclk_i);
         mc_done_i <= 1'h0;
         ticks(2);
         `CHK(done_irq_o, 1'h1)
         rd_chk(10'h014, 8'hA0 | {6'h00, err});
         wb_xfer(1'h1, 10'h014, 8'h20);
      end else begin
         rd_chk(10'h014, 8'h90);
         wb_xfer(1'h1, 10'h014, 8'h80);
         ticks(3);
         `CHK(n_start, s)
         wb_xfer(1'h1, 10'h014, 8'h10);
         rd_chk(10'h014, 8'h80);
      end
   endtask

   initial begin
      @(posedge mclk_i);
      // the loaded protection byte keeps its reserved nonvolatile bit erased
      do_reset(8'hA4, 1'h0);
      wb_xfer(1'h1, 10'h010, 8'hFF);
      rd_chk(10'h010, 8'h80);
      `CHK(done_irq_o, 1'h1)
      wb_xfer(1'h1, 10'h010, 8'h00);
      ticks(1);
      `CHK(done_irq_o, 1'h0)
      $display("test config done");
      for (int i = 0; i < 7; i++) begin
         seed = lfsr_next(seed);
         words[i] = (i < 6) ? seed[15:0] : 16'h0000;
         set_word(i, seed[15:0]);
      end
      for (int i = 0; i < 7; i++) begin
         wb_xfer(1'h1, 10'h008, i[7:0]);
         rd_chk(10'h008, i[7:0]);
         rd_chk(10'h020, words[i][7:0]);
         rd_chk(10'h024, words[i][15:8]);
      end
      `CHK(mc_cob_o[95:80], words[5])
      $display("test command words done");
      wb_xfer(1'h1, 10'h03C, ~opt);
      rd_chk(10'h03C, opt);
      rd_chk(10'h030, 8'h00);
      foreach (pw[i]) begin
         wb_xfer(1'h1, 10'h02C, pw[i]);
         rd_chk(10'h02C, pe[i]);
      end
      `CHK(protect_o, 8'h9B)
      $display("test protection writes done");
      wb_xfer(1'h1, 10'h010, 8'h80);
      launch(fpr_pkg::CMD_PROGRAM, 16'h7000, 1'h0, 2'h0);
      launch(fpr_pkg::CMD_ERASE_SECTOR, 16'h0100, 1'h0, 2'h0);
      launch(fpr_pkg::CMD_ERASE_BLOCK, 16'h5000, 1'h0, 2'h0);
      seed = lfsr_next(seed);
      launch(fpr_pkg::CMD_PROGRAM, 16'h5000, 1'h1, seed[1:0]);
      $display("test launches done");
      `CHK(unsecure_o, 1'h0)
      mc_err_i <= 2'h0;
      mass_erase_i <= 1'h1;
      for (int op = 1; op < 4; op++) begin
         s = n_start;
         repeat (30) if (n_start == s) @(posedge mclk_i);
         `CHK(mc_op_o, fpr_pkg::fpr_mcop_t'(op))
         rd_chk(10'h010, 8'hA0);
         mc_done_i <= 1'h1;
         @(posedge mclk_i);
         mc_done_i <= 1'h0;
      end
      ticks(3);
      `CHK(unsecure_o, 1'h1)
      rd_chk(10'h010, 8'h80);
      rd_chk(10'h014, 8'h80 | {6'h00, seed[1:0]});
      mass_erase_i <= 1'h0;
      $display("test mass erase done");
      // select clear: the enabled ranges are the only open ones
      do_reset(8'h00, 1'h0);
      wb_xfer(1'h1, 10'h010, 8'h80);
      launch(fpr_pkg::CMD_PROGRAM, 16'h5000, 1'h0, 2'h0);
      launch(fpr_pkg::CMD_PROGRAM, 16'h0100, 1'h1, 2'h0);
      $display("test open ranges done");
      do_reset(8'hA4, 1'h1);
      wb_xfer(1'h0, 10'h014, 8'h00);
      `CHK(rd[1:0], fpr_pkg::MG_NV_FAULT)
      $display("test load fault done");
      give_verdict();
   end
endmodule
